//--- src/ubg_pkg.sv
// shared constants and types for the receive filter and baud generator
package ubg_pkg;

  // ---------------------------------------------------------------
  // register byte addresses on the wishbone bus
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_BAUD = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_TXD  = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEL_HI   = 7;
  localparam int SEL_LO   = 6;
  localparam int DIV_MSB  = 4;
  localparam int PWR_BIT  = 7;
  localparam int TXE_BIT  = 6;
  localparam int RXE_BIT  = 5;
  localparam int FLEN_MSB = 3;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] BAUD_RST = 8'h48;
  localparam logic [7:0] MODE_RST = 8'h0a;

  // ---------------------------------------------------------------
  // divider constants
  // ---------------------------------------------------------------
  localparam logic [4:0] K_MIN      = 5'h08;
  localparam logic [4:0] PRE_MASK2  = 5'h01;
  localparam logic [4:0] PRE_MASK8  = 5'h07;
  localparam logic [4:0] PRE_MASK32 = 5'h1f;

  typedef enum logic [1:0] {
    SEL_TIMER = 2'b00,
    SEL_DIV2  = 2'b01,
    SEL_DIV8  = 2'b10,
    SEL_DIV32 = 2'b11
  } ubg_clk_sel_t;

  typedef enum logic [1:0] {
    RX_IDLE   = 2'b00,
    RX_VERIFY = 2'b01,
    RX_RECV   = 2'b11
  } ubg_rx_st_t;

  // divisor below the legal range is raised to the smallest legal k
  function automatic logic [4:0] ubg_k(input logic [4:0] raw);
    ubg_k = (raw < K_MIN) ? K_MIN : raw;
  endfunction

endpackage

//--- src/ubg_baud_cnt.sv
// 5-bit programmable counter that produces one serial clock phase
`timescale 1ns/100ps
module ubg_baud_cnt
  import ubg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       clr,
  input  wire logic [4:0] k,
  output logic      [4:0] cnt_ff,
  output logic            phase_ff,
  output logic            half_ff
);

  // ---------------------------------------------------------------
  // count base clocks, toggle phase every k of them
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn || !run || clr) begin
      cnt_ff   <= 5'h00;
      phase_ff <= 1'b0;
      half_ff  <= 1'b0;
    end else begin
      half_ff <= 1'b0;
      if (tick) begin
        if (cnt_ff == k - 5'h01) begin
          cnt_ff   <= 5'h00;
          phase_ff <= ~phase_ff;
          half_ff  <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end
    end
  end

endmodule

//--- src/ubg_top.sv
// receive noise filter and dedicated baud rate generator with wishbone registers
//
// How it works
// - the receive pin is sampled on each base clock and the filter output follows only two equal samples.
// - the filtered value lags the pin by two base clock cycles.
// - separate 5-bit transmit and receive counters both run from the selected base clock.
// - the base clock reaches the logic only while the power bit is set and stays low otherwise.
// - the two-bit select field picks timer output, or peripheral clock over 2, 8 or 32.
// - the transmit counter is held at zero while power or transmit enable is off.
// - the transmit counter counts base clocks once power and transmit enable are both on.
// - writing transmit data clears the transmit counter so bit timing starts with the frame.
// - the receive counter is held at zero while power or receive enable is off.
// - the receive counter starts only on a start edge of the filtered input.
// - after one frame the receive counter halts until the next start bit.
// - the five-bit divisor field sets k from 8 to 31, the serial clock being base clock over 16 to 62.
// - the bit rate is the base clock over twice k.
// - on a falling edge the receive side waits k base clocks and accepts a start bit only if still low.
`timescale 1ns/100ps
module ubg_top
  import ubg_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        RX_SERIAL_IN,
  input  wire logic        TIMER_OUT_IN,
  output logic             BASE_CLK_O,
  output logic             RX_FILT_O,
  output logic             RX_START_O,
  output logic             RX_SAMPLE_O,
  output logic             TX_SCLK_O,
  output logic             RX_SCLK_O
);

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic [7:0] baud_ctrl_reg_ff;
  logic [7:0] async_mode_reg_ff;
  logic [7:0] tx_shift_reg_ff;
  logic       ack_ff;
  logic [31:0] rdat_ff;
  logic       req;
  logic       wr;
  logic       tx_wr;
  logic [31:0] nxt_rdat;

  logic       port_power_on;
  logic       tx_enable_bit;
  logic       rx_enable_bit;
  logic [1:0] clk_sel;
  logic [4:0] k_val;
  logic [3:0] frame_len;

  logic       rx_filt_ff;
  logic [4:0] tx_cnt;
  logic [4:0] rx_cnt;
  logic       tx_phase;
  logic       rx_phase;
  logic       rx_half;
  ubg_rx_st_t rx_st_ff;

  // one wait state: ack rises on the edge after the request appears
  assign req   = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr    = req && WB_WE_I && WB_SEL_I[0];
  assign tx_wr = wr && (WB_ADR_I == ADR_TXD);

  assign port_power_on = async_mode_reg_ff[PWR_BIT];
  assign tx_enable_bit = async_mode_reg_ff[TXE_BIT];
  assign rx_enable_bit = async_mode_reg_ff[RXE_BIT];
  assign clk_sel       = baud_ctrl_reg_ff[SEL_HI:SEL_LO];
  assign k_val         = ubg_k(baud_ctrl_reg_ff[DIV_MSB:0]);
  assign frame_len     = async_mode_reg_ff[FLEN_MSB:0];

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      baud_ctrl_reg_ff  <= BAUD_RST;
      async_mode_reg_ff <= MODE_RST;
      tx_shift_reg_ff   <= 8'h00;
    end else if (wr) begin
      case (WB_ADR_I)
        ADR_BAUD: baud_ctrl_reg_ff  <= WB_DAT_I[7:0];
        ADR_MODE: async_mode_reg_ff <= WB_DAT_I[7:0];
        ADR_TXD:  tx_shift_reg_ff   <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_rdat = 32'h0000_0000;
    case (WB_ADR_I)
      ADR_BAUD: nxt_rdat[7:0] = baud_ctrl_reg_ff;
      ADR_MODE: nxt_rdat[7:0] = async_mode_reg_ff;
      ADR_TXD:  nxt_rdat[7:0] = tx_shift_reg_ff;
      ADR_STAT: nxt_rdat = {11'h000, rx_cnt, 3'h0, tx_cnt, 3'h0, rx_st_ff, rx_phase,
                            tx_phase, rx_filt_ff};
      default:  nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req) begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rx_sync_ff;
  logic [1:0] tmr_sync_ff;
  logic       tmr_prev_ff;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rx_sync_ff  <= 2'b11;
      tmr_sync_ff <= 2'b00;
      tmr_prev_ff <= 1'b0;
    end else begin
      rx_sync_ff  <= {rx_sync_ff[0], RX_SERIAL_IN};
      tmr_sync_ff <= {tmr_sync_ff[0], TIMER_OUT_IN};
      tmr_prev_ff <= tmr_sync_ff[1];
    end
  end

  // ---------------------------------------------------------------
  // base clock selection and power gating
  // ---------------------------------------------------------------
  logic [4:0] pre_ff;
  logic       base_tick_ff;
  logic       nxt_tick;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !port_power_on) begin
      pre_ff <= 5'h00;
    end else begin
      pre_ff <= pre_ff + 5'h01;
    end
  end

  always_comb begin
    case (clk_sel)
      SEL_TIMER: nxt_tick = tmr_sync_ff[1] && !tmr_prev_ff;
      SEL_DIV2:  nxt_tick = (pre_ff & PRE_MASK2) == PRE_MASK2;
      SEL_DIV8:  nxt_tick = (pre_ff & PRE_MASK8) == PRE_MASK8;
      default:   nxt_tick = (pre_ff & PRE_MASK32) == PRE_MASK32;
    endcase
  end

  // a gated enable instead of a gated clock keeps one clock tree
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      base_tick_ff <= 1'b0;
    end else begin
      base_tick_ff <= nxt_tick && port_power_on;
    end
  end

  assign BASE_CLK_O = base_tick_ff;

  // ---------------------------------------------------------------
  // receive noise filter
  // ---------------------------------------------------------------
  logic smp_ff;
  logic filt_prev_ff;
  logic rx_fall;

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !port_power_on) begin
      smp_ff     <= 1'b1;
      rx_filt_ff <= 1'b1;
    end else if (base_tick_ff) begin
      smp_ff <= rx_sync_ff[1];
      if (rx_sync_ff[1] == smp_ff) begin
        rx_filt_ff <= smp_ff;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      filt_prev_ff <= 1'b1;
    end else begin
      filt_prev_ff <= rx_filt_ff;
    end
  end

  assign rx_fall   = filt_prev_ff && !rx_filt_ff;
  assign RX_FILT_O = rx_filt_ff;

  // ---------------------------------------------------------------
  // transmit and receive counters
  // ---------------------------------------------------------------
  logic tx_run;
  logic rx_run;
  logic rx_clr;

  assign tx_run = port_power_on && tx_enable_bit;
  assign rx_clr = (rx_st_ff == RX_IDLE) && rx_fall;
  assign rx_run = port_power_on && rx_enable_bit && (rx_st_ff != RX_IDLE);

  ubg_baud_cnt u_tx_cnt (
    .clk      (SYS_CLK),
    .rstn     (RESETN),
    .tick     (base_tick_ff),
    .run      (tx_run),
    .clr      (tx_wr),
    .k        (k_val),
    .cnt_ff   (tx_cnt),
    .phase_ff (tx_phase),
    .half_ff  ()
  );

  ubg_baud_cnt u_rx_cnt (
    .clk      (SYS_CLK),
    .rstn     (RESETN),
    .tick     (base_tick_ff),
    .run      (rx_run),
    .clr      (rx_clr),
    .k        (k_val),
    .cnt_ff   (rx_cnt),
    .phase_ff (rx_phase),
    .half_ff  (rx_half)
  );

  assign TX_SCLK_O = tx_phase;
  assign RX_SCLK_O = rx_phase;

  // ---------------------------------------------------------------
  // receive start detection and frame length
  // ---------------------------------------------------------------
  logic [3:0] bits_ff;
  logic       start_ff;
  logic       sample_ff;

  // sampling points fall where phase turns high: mid-bit, 2k apart
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN || !port_power_on || !rx_enable_bit) begin
      rx_st_ff  <= RX_IDLE;
      bits_ff   <= 4'h0;
      start_ff  <= 1'b0;
      sample_ff <= 1'b0;
    end else begin
      start_ff  <= 1'b0;
      sample_ff <= 1'b0;
      case (rx_st_ff)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_st_ff <= RX_VERIFY;
          end
        end
        RX_VERIFY: begin
          if (rx_half) begin
            bits_ff <= 4'h1;
            if (!rx_filt_ff) begin
              rx_st_ff <= RX_RECV;
              start_ff <= 1'b1;
            end else begin
              rx_st_ff <= RX_IDLE;
            end
          end
        end
        RX_RECV: begin
          if (rx_half && rx_phase) begin
            sample_ff <= 1'b1;
            bits_ff   <= bits_ff + 4'h1;
            if (bits_ff + 4'h1 >= frame_len) begin
              rx_st_ff <= RX_IDLE;
            end
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  assign RX_START_O  = start_ff;
  assign RX_SAMPLE_O = sample_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_filt_agree;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ($changed(rx_filt_ff) && port_power_on && $past(port_power_on))
      |-> $past(base_tick_ff) && ($past(smp_ff) == rx_filt_ff);
  endproperty
  a_filt_agree: assert property (p_filt_agree) else $error("filter moved without match");

  property p_filt_lag;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (port_power_on && base_tick_ff && rx_sync_ff[1] != smp_ff)
      |=> $stable(rx_filt_ff);
  endproperty
  a_filt_lag: assert property (p_filt_lag) else $error("filter followed a lone sample");

  property p_filt_idle;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !port_power_on |=> rx_filt_ff;
  endproperty
  a_filt_idle: assert property (p_filt_idle) else $error("filter not idle high");

  property p_gate;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !port_power_on ##1 !port_power_on |-> !base_tick_ff;
  endproperty
  a_gate: assert property (p_gate) else $error("base clock while powered off");

  property p_div8;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (base_tick_ff && clk_sel == SEL_DIV8 && $past(clk_sel) == SEL_DIV8)
      |=> (!base_tick_ff || clk_sel != SEL_DIV8) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 too fast");

  property p_tx_hold;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !tx_run |=> tx_cnt == 5'h00 && !tx_phase;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit counter not held");

  property p_tx_clr;
    @(posedge SYS_CLK) disable iff (!RESETN)
      tx_wr |=> tx_cnt == 5'h00;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("transmit counter not cleared");

  property p_rx_hold;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !(port_power_on && rx_enable_bit) |=> rx_cnt == 5'h00 && rx_st_ff == RX_IDLE;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive counter not held");

  property p_rx_wait;
    @(posedge SYS_CLK) disable iff (!RESETN)
      rx_cnt != 5'h00 |-> $past(rx_st_ff) != RX_IDLE;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("receive counter ran while idle");

  property p_verify;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (rx_st_ff == RX_VERIFY && rx_half && rx_filt_ff && rx_enable_bit && port_power_on)
      |=> rx_st_ff == RX_IDLE && !start_ff;
  endproperty
  a_verify: assert property (p_verify) else $error("false start accepted");

  property p_toggle;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ($changed(tx_phase) && tx_phase && $past(tx_run) && !$past(tx_wr))
      |-> $past(tx_cnt) == $past(k_val) - 5'h01;
  endproperty
  a_toggle: assert property (p_toggle) else $error("serial clock off k");

  c_start: cover property (@(posedge SYS_CLK) disable iff (!RESETN) start_ff);
  c_frame: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    rx_st_ff == RX_RECV ##1 rx_st_ff == RX_IDLE);
  c_timer: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    base_tick_ff && clk_sel == SEL_TIMER);

endmodule

//--- testbench/ubg_remote_tx.sv
// behavioural far end: remote serial transmitter and the external timer output
`timescale 1ns/100ps
module ubg_remote_tx (
  input  wire logic clk,
  output logic      line_o,
  output logic      timer_o
);
  int   tmr_half = 0;
  int   tcnt     = 0;
  logic tmr_run  = 1'b0;
  logic inv_en   = 1'b0;

  initial begin
    line_o  = 1'b1;
    timer_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // timer output, toggles only once the timer runs and inversion is on
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (tmr_run && inv_en) begin
      if (tcnt >= tmr_half - 1) begin
        tcnt    <= 0;
        timer_o <= ~timer_o;
      end else begin
        tcnt <= tcnt + 1;
      end
    end
  end

  // timer first, inversion a cycle later, so the first edge is clean
  task automatic start_timer(input int half);
    tmr_half = half;
    @(posedge clk);
    tmr_run <= 1'b1;
    @(posedge clk);
    inv_en <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // frames are sent lsb first; the line rests high between them
  // ---------------------------------------------------------------
  task automatic send(input logic [15:0] frame, input int nbits, input int bit_cyc);
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      line_o <= frame[i];
      repeat (bit_cyc - 1) @(posedge clk);
    end
    @(posedge clk);
    line_o <= 1'b1;
  endtask

  task automatic glitch(input int n);
    @(posedge clk);
    line_o <= 1'b0;
    repeat (n) @(posedge clk);
    line_o <= 1'b1;
  endtask
endmodule

//--- testbench/tb_uart_rx_filter_baud_generator.sv
// self-checking bench for the receive filter and baud generator
`timescale 1ns/100ps
module tb_uart_rx_filter_baud_generator;
  import ubg_pkg::*;
  localparam int M_BASE = 0;
  localparam int M_TX   = 1;
  localparam int M_RSCK = 2;
  localparam int M_SMP  = 4;
  localparam int M_STRT = 3;
  localparam int M_FILT = 5;
  localparam int THALF  = 5;
  localparam int LIMIT  = 60000;

  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [31:0] wb_dat  = 32'h0;
  logic        wb_we   = 1'b0;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  wire  [31:0] wb_rdat;
  wire         wb_ack;
  wire         rx_line;
  wire         tmr_out;
  wire  [5:0]  mon;
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc_cnt   = 0;

  always #50 sys_clk = ~sys_clk;

  ubg_remote_tx i_rem (.clk(sys_clk), .line_o(rx_line), .timer_o(tmr_out));

  ubg_top i_dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat),
    .WB_SEL_I(4'h1), .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .RX_SERIAL_IN(rx_line),
    .TIMER_OUT_IN(tmr_out), .BASE_CLK_O(mon[0]), .TX_SCLK_O(mon[1]),
    .RX_SCLK_O(mon[2]), .RX_START_O(mon[3]), .RX_SAMPLE_O(mon[4]), .RX_FILT_O(mon[5])
  );

  // ---------------------------------------------------------------
  // closing, comparisons and helpers
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      $display("ERROR %0t: run did not finish", $time);
      finish_test();
    end
  end

  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  function automatic int exp_pulses(input int s, input int win);
    case (s)
      0: exp_pulses = win / (2 * THALF);
      1: exp_pulses = win / 2;
      2: exp_pulses = win / 8;
      default: exp_pulses = win / 32;
    endcase
  endfunction

  // classic single cycle: hold everything until ack is seen at an edge
  task automatic wb_rw(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    if (n >= 50) chk_in(n, 0, 49);
  endtask

  // edges until a monitored output shows the value, at least one edge
  task automatic wait_val(input int idx, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (mon[idx] !== v && n < lim);
  endtask

  task automatic count_eq(input int idx, input logic v, input int win, output int n);
    n = 0;
    repeat (win) begin
      @(posedge sys_clk);
      if (mon[idx] === v) n++;
    end
  endtask

  // filtered fall, start confirm after k ticks, then samples every 2k
  task automatic rx_frame(input int k, input int nb, input logic [7:0] d);
    int n;
    logic [31:0] q;
    wb_rw(1'b1, ADR_BAUD, {3'b010, k[4:0]}, q);
    wb_rw(1'b1, ADR_MODE, {4'ha, nb[3:0]}, q);
    repeat (10) @(posedge sys_clk);
    fork
      i_rem.send({6'h3f, 1'b1, d, 1'b0}, nb, 4 * k);
      begin
        wait_val(M_FILT, 1'b0, 200, n);
        chk_in(n, 4, 12);
        wait_val(M_STRT, 1'b1, 400, n);
        chk_in(n, 2 * k - 2, 2 * k + 5);
        chk_eq(mon[M_RSCK], 32'h1);
        repeat (nb - 1) begin
          wait_val(M_SMP, 1'b1, 400, n);
          chk_in(n, 4 * k, 4 * k);
          chk_eq(mon[M_RSCK], 32'h1);
        end
      end
    join
    repeat (20) @(posedge sys_clk);
    wb_rw(1'b0, ADR_STAT, 8'h00, q);
    chk_eq({q[20:16], q[4:2]}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    int n;
    logic [31:0] q;
    logic [7:0]  d;
    void'($urandom(32'hd32baf85));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    wb_rw(1'b0, ADR_BAUD, 8'h00, q);
    chk_eq(q, {24'h0, BAUD_RST});
    wb_rw(1'b0, ADR_MODE, 8'h00, q);
    chk_eq(q, {24'h0, MODE_RST});
    wb_rw(1'b1, 8'h10, 8'hff, q);
    wb_rw(1'b0, 8'h10, 8'h00, q);
    chk_eq(q, 32'h0);
    count_eq(M_BASE, 1'b1, 100, n);
    chk_in(n, 0, 0);
    repeat (4) begin
      d = 8'($urandom()) & 8'hdf;
      wb_rw(1'b1, ADR_BAUD, d, q);
      wb_rw(1'b0, ADR_BAUD, 8'h00, q);
      chk_eq(q, {24'h0, d});
    end
    // every base clock source, timer output included
    i_rem.start_timer(THALF);
    for (int s = 0; s < 4; s++) begin
      wb_rw(1'b1, ADR_BAUD, {s[1:0], 6'h08}, q);
      wb_rw(1'b1, ADR_MODE, 8'h8a, q);
      repeat (40) @(posedge sys_clk);
      count_eq(M_BASE, 1'b1, 160, n);
      chk_in(n, exp_pulses(s, 160), exp_pulses(s, 160));
    end
    wb_rw(1'b1, ADR_MODE, 8'h0a, q);
    repeat (3) @(posedge sys_clk);
    count_eq(M_BASE, 1'b1, 100, n);
    chk_in(n, 0, 0);
    // transmit counter at base clock over 32
    k = $urandom_range(31, 8);
    wb_rw(1'b1, ADR_BAUD, {3'b110, k[4:0]}, q);
    wb_rw(1'b1, ADR_MODE, 8'hca, q);
    wait_val(M_TX, ~mon[M_TX], 3000, n);
    wait_val(M_TX, ~mon[M_TX], 3000, n);
    chk_in(n, 32 * k, 32 * k);
    wait_val(M_TX, ~mon[M_TX], 3000, n);
    chk_in(n, 32 * k, 32 * k);
    wb_rw(1'b1, ADR_TXD, 8'h55, q);
    wb_rw(1'b0, ADR_STAT, 8'h00, q);
    chk_eq({q[20:16], q[12:9]}, 32'h0);
    wb_rw(1'b1, ADR_MODE, 8'h8a, q);
    wb_rw(1'b0, ADR_STAT, 8'h00, q);
    chk_eq({q[12:8], q[1]}, 32'h0);
    // reception at base clock over 2, two frames of different length
    rx_frame(8, 10, 8'($urandom()));
    rx_frame($urandom_range(31, 9), 9, 8'($urandom()));
    // glitch shorter than one base clock at over 8 must not pass
    wb_rw(1'b1, ADR_BAUD, 8'h88, q);
    repeat (20) @(posedge sys_clk);
    fork
      i_rem.glitch(3);
      count_eq(M_FILT, 1'b0, 300, n);
    join
    chk_in(n, 0, 0);
    // receive enable off: a full frame leaves no trace
    wb_rw(1'b1, ADR_MODE, 8'h8a, q);
    fork
      i_rem.send(16'hffaa, 10, 40);
      count_eq(M_STRT, 1'b1, 500, n);
    join
    chk_in(n, 0, 0);
    finish_test();
  end
endmodule
